// ===== core/dss_map.vh
`ifndef DSS_MAP_VH
`define DSS_MAP_VH

// ----------------------------------------
// clock and timing
// ----------------------------------------
`define DSS_CLK_PERIOD_NS 50
`define DSS_RH_PULSE_NS 300
`define DSS_RH_PULSE_CYC ((`DSS_RH_PULSE_NS + `DSS_CLK_PERIOD_NS - 1) / `DSS_CLK_PERIOD_NS)
`define DSS_CNT_W 16
`define DSS_AZ_LEN 10001
`define DSS_INT_LEN 10000
`define DSS_REF_LIMIT 20000
`define DSS_CYCLE_LEN 40002
`define DSS_IZ_NORM_LEN 150
`define DSS_IZ_OVR_LEN 6200

// ----------------------------------------
// register map
// ----------------------------------------
`define DSS_CTRL_OFS 8'h00
`define DSS_STATUS_OFS 8'h04
`define DSS_RESULT_OFS 8'h08
`define DSS_CTRL_RESET 2'h0
`define DSS_CTRL_HOLD_BIT 0
`define DSS_CTRL_SHOT_BIT 1
`define DSS_STAT_BUSY_BIT 0
`define DSS_STAT_POL_BIT 1
`define DSS_STAT_OVR_BIT 2
`define DSS_STAT_PHASE_LSB 3
`define DSS_RESP_OKAY 2'h0
`define DSS_RESP_SLVERR 2'h2

`endif

// ===== core/dual_slope_conversion_sequencer.v
`timescale 1ns/10ps
`include "dss_map.vh"
module dual_slope_conversion_sequencer #(
   parameter AZ_LEN = `DSS_AZ_LEN,
   parameter INT_LEN = `DSS_INT_LEN,
   parameter REF_LIMIT = `DSS_REF_LIMIT,
   parameter CYCLE_LEN = `DSS_CYCLE_LEN,
   parameter IZ_OVR_LEN = `DSS_IZ_OVR_LEN
) (
   input wire aclk,
   input wire aresetn,
   input wire run_hold,
   input wire comparator_high,
   output reg input_connect_switch,
   output reg ref_positive_switch,
   output reg ref_negative_switch,
   output reg autozero_loop_switch,
   output reg ref_charge_switch,
   output reg integrator_common_switch,
   output reg integrator_clear_switch,
   output reg busy,
   output reg polarity,
   output reg overrange,
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready
);
   // ----------------------------------------
   // phases and constants
   // ----------------------------------------
   localparam [4:0] PH_SZ = 5'h01;
   localparam [4:0] PH_INT = 5'h02;
   localparam [4:0] PH_REF = 5'h04;
   localparam [4:0] PH_IZ = 5'h08;
   localparam [4:0] PH_HOLD = 5'h10;
   localparam W = `DSS_CNT_W;
   localparam integer IZ_NORM_LEN = `DSS_IZ_NORM_LEN;
   localparam integer PULSE_CYC = `DSS_RH_PULSE_CYC;
   // lengths are integers; part-selects make the narrowing to counter width deliberate
   localparam [W-1:0] AZ_LAST = AZ_LEN[W-1:0] - 16'h0001;
   localparam [W-1:0] INT_LAST = INT_LEN[W-1:0] - 16'h0001;
   localparam [W-1:0] REF_OVR = REF_LIMIT[W-1:0];
   localparam [W-1:0] CYC_LAST = CYCLE_LEN[W-1:0] - 16'h0001;
   localparam [W-1:0] IZ_NORM_LAST = IZ_NORM_LEN[W-1:0] - 16'h0001;
   localparam [W-1:0] IZ_OVR_LAST = IZ_OVR_LEN[W-1:0] - 16'h0001;
   localparam [3:0] PULSE_LAST = PULSE_CYC[3:0] - 4'h1;

   reg [4:0] phase_q, phase_d;
   reg tail_q, tail_d;
   reg ovr_pend_q, ovr_pend_d;
   reg busy_d, polarity_d, overrange_d;
   reg start_d;
   reg load_q;
   reg [W-1:0] ref_count_q, ref_count_d;
   reg [W-1:0] result_q;
   reg [3:0] hi_cnt_q;
   reg [1:0] ctrl_q;
   reg shot_q;
   wire run_s;
   wire comp_s;
   wire [W-1:0] phase_cnt;
   wire [W-1:0] cyc_cnt;
   wire run_eff;
   wire crossing;
   wire pulse_seen;

   // ----------------------------------------
   // input synchronisers and counters
   // ----------------------------------------
   // reset value 1: a floating pin is pulled up at the pad
   sync_2ff #(.RESET_VAL(1'b1)) u_run_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .async_in(run_hold),
      .sync_out(run_s)
   );

   sync_2ff #(.RESET_VAL(1'b0)) u_comp_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .async_in(comparator_high),
      .sync_out(comp_s)
   );

   sat_counter #(.WIDTH(W)) u_phase_cnt (
      .aclk(aclk),
      .aresetn(aresetn),
      .clr((phase_d != phase_q) | start_d),
      .count(phase_cnt)
   ); // fixed phases timed by clock pulses

   sat_counter #(.WIDTH(W)) u_cycle_cnt (
      .aclk(aclk),
      .aresetn(aresetn),
      .clr(start_d),
      .count(cyc_cnt)
   );

   // software hold acts like run/hold held low
   assign run_eff = run_s & ~ctrl_q[`DSS_CTRL_HOLD_BIT];
   // integrator back at zero once comparator leaves input sign
   assign crossing = (comp_s != polarity);
   // single-shot needs a high level of more than 300 ns
   assign pulse_seen = run_eff & (hi_cnt_q == PULSE_LAST);

   // ----------------------------------------
   // phase sequencing
   // ----------------------------------------
   // next phase, busy, polarity and overrange
   always @* begin
      phase_d = phase_q;
      tail_d = tail_q;
      ovr_pend_d = ovr_pend_q;
      busy_d = busy;
      polarity_d = polarity;
      overrange_d = overrange;
      ref_count_d = ref_count_q;
      start_d = 1'b0;
      case (phase_q)
         PH_SZ: begin
            if (!tail_q && phase_cnt == AZ_LAST) begin
               phase_d = PH_INT;
               busy_d = 1'b1;
            end else if (tail_q && cyc_cnt >= CYC_LAST) begin
               if (run_eff) begin
                  start_d = 1'b1; // continuous period
                  tail_d = 1'b0;
               end else begin
                  phase_d = PH_HOLD; // finish then hold
               end
            end
         end
         PH_INT: begin
            if (phase_cnt == INT_LAST) begin
               phase_d = PH_REF;
               polarity_d = comp_s; // one means positive
               overrange_d = 1'b0;
               ovr_pend_d = 1'b0;
            end
         end
         PH_REF: begin
            if (crossing) begin
               phase_d = PH_IZ;
               busy_d = 1'b0;
               ref_count_d = phase_cnt;
            end else if (phase_cnt == REF_OVR) begin
               phase_d = PH_IZ; // count reached the limit
               ovr_pend_d = 1'b1;
               ref_count_d = phase_cnt;
            end
         end
         PH_IZ: begin
            if (phase_cnt == (ovr_pend_q ? IZ_OVR_LAST : IZ_NORM_LAST)) begin
               tail_d = 1'b1;
               if (ovr_pend_q) begin
                  busy_d = 1'b0; // overrange: busy ends with integrator zero
                  overrange_d = 1'b1; // set as busy falls
               end
               if (cyc_cnt >= CYC_LAST && run_eff) begin
                  phase_d = PH_SZ;
                  start_d = 1'b1;
                  tail_d = 1'b0;
               end else if (cyc_cnt >= CYC_LAST) begin
                  phase_d = PH_HOLD;
               end else begin
                  phase_d = PH_SZ;
               end
            end
         end
         PH_HOLD: begin
            // only reachable after the running cycle ended
            if (pulse_seen || shot_q) begin
               phase_d = PH_SZ; // one new measurement
               start_d = 1'b1;
               tail_d = 1'b0;
            end
         end
         default: begin
            phase_d = PH_SZ;
            start_d = 1'b1;
            tail_d = 1'b0;
         end
      endcase
   end

   // state, status and result registers
   always @(posedge aclk) begin
      if (!aresetn) begin
         phase_q <= PH_SZ;
         tail_q <= 1'b0;
         ovr_pend_q <= 1'b0;
         busy <= 1'b0;
         polarity <= 1'b0;
         overrange <= 1'b0;
         ref_count_q <= {W{1'b0}};
         load_q <= 1'b0;
         result_q <= {W{1'b0}};
         hi_cnt_q <= 4'h0;
      end else begin
         phase_q <= phase_d;
         tail_q <= tail_d;
         ovr_pend_q <= ovr_pend_d;
         busy <= busy_d;
         polarity <= polarity_d;
         overrange <= overrange_d;
         ref_count_q <= ref_count_d;
         load_q <= busy & ~busy_d;
         if (load_q) begin
            result_q <= ref_count_q; // first clock after busy low
         end
         // high-time counter only runs while holding
         if (phase_q != PH_HOLD || !run_eff) begin
            hi_cnt_q <= 4'h0;
         end else if (hi_cnt_q != PULSE_LAST) begin
            hi_cnt_q <= hi_cnt_q + 4'h1;
         end
      end
   end

   // ----------------------------------------
   // analog switch enables
   // ----------------------------------------
   // registered from next phase so pins track the phase exactly
   always @(posedge aclk) begin
      if (!aresetn) begin
         input_connect_switch <= 1'b0;
         ref_positive_switch <= 1'b0;
         ref_negative_switch <= 1'b0;
         autozero_loop_switch <= 1'b1;
         ref_charge_switch <= 1'b1;
         integrator_common_switch <= 1'b1;
         integrator_clear_switch <= 1'b0;
      end else begin
         input_connect_switch <= (phase_d == PH_INT);
         ref_positive_switch <= (phase_d == PH_REF) & polarity_d;
         ref_negative_switch <= (phase_d == PH_REF) & ~polarity_d;
         // hold keeps the zero loop closed so offsets stay trimmed
         autozero_loop_switch <= (phase_d == PH_SZ) | (phase_d == PH_HOLD);
         ref_charge_switch <= (phase_d == PH_SZ) | (phase_d == PH_HOLD);
         integrator_common_switch <= (phase_d != PH_INT);
         integrator_clear_switch <= (phase_d == PH_IZ);
      end
   end

   // ----------------------------------------
   // axi4-lite slave
   // ----------------------------------------
   reg [7:0] aw_addr_q;
   reg aw_held_q, w_held_q;
   reg [31:0] w_data_q;
   reg [3:0] w_strb_q;
   reg [31:0] rd_mux;
   // word-aligned addresses, full width so decodes compare like with like
   wire [7:0] aw_word = {aw_addr_q[7:2], 2'b00};
   wire [7:0] ar_word = {s_axi_araddr[7:2], 2'b00};

   // write side: address and data taken in either order
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `DSS_RESP_OKAY;
         aw_held_q <= 1'b0;
         w_held_q <= 1'b0;
         aw_addr_q <= 8'h00;
         w_data_q <= 32'h00000000;
         w_strb_q <= 4'h0;
         ctrl_q <= `DSS_CTRL_RESET;
         shot_q <= 1'b0;
      end else begin
         shot_q <= 1'b0;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_addr_q <= s_axi_awaddr;
            aw_held_q <= 1'b1;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
            w_held_q <= 1'b1;
            s_axi_wready <= 1'b0;
         end
         if (aw_held_q && w_held_q && !s_axi_bvalid) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            if (aw_word == `DSS_CTRL_OFS) begin
               s_axi_bresp <= `DSS_RESP_OKAY;
               if (w_strb_q[0]) begin
                  ctrl_q[`DSS_CTRL_HOLD_BIT] <= w_data_q[`DSS_CTRL_HOLD_BIT];
                  shot_q <= w_data_q[`DSS_CTRL_SHOT_BIT]; // self-clearing trigger
               end
            end else if (aw_word == `DSS_STATUS_OFS || aw_word == `DSS_RESULT_OFS) begin
               s_axi_bresp <= `DSS_RESP_OKAY; // read-only, write dropped
            end else begin
               s_axi_bresp <= `DSS_RESP_SLVERR;
            end
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   // read data selection
   always @* begin
      rd_mux = 32'h00000000;
      case (ar_word)
         `DSS_CTRL_OFS: rd_mux[1:0] = ctrl_q & 2'h1;
         `DSS_STATUS_OFS: begin
            rd_mux[`DSS_STAT_BUSY_BIT] = busy;
            rd_mux[`DSS_STAT_POL_BIT] = polarity;
            rd_mux[`DSS_STAT_OVR_BIT] = overrange;
            rd_mux[`DSS_STAT_PHASE_LSB +: 5] = phase_q;
         end
         `DSS_RESULT_OFS: rd_mux[W-1:0] = result_q;
         default: rd_mux = 32'h00000000;
      endcase
   end

   // read side: one outstanding read
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `DSS_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_mux;
         if (ar_word == `DSS_CTRL_OFS || ar_word == `DSS_STATUS_OFS ||
             ar_word == `DSS_RESULT_OFS) begin
            s_axi_rresp <= `DSS_RESP_OKAY;
         end else begin
            s_axi_rresp <= `DSS_RESP_SLVERR;
         end
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end
endmodule // dual_slope_conversion_sequencer

// ===== core/sat_counter.v
`timescale 1ns/10ps
// ----------------------------------------
// saturating up-counter with clear
// ----------------------------------------
module sat_counter #(
   parameter WIDTH = 16
) (
   input wire aclk,
   input wire aresetn,
   input wire clr,
   output wire [WIDTH-1:0] count
);
   reg [WIDTH-1:0] cnt_q;

   // saturate so an overlong phase cannot wrap into a short one
   always @(posedge aclk) begin
      if (!aresetn || clr) begin
         cnt_q <= {WIDTH{1'b0}};
      end else if (cnt_q != {WIDTH{1'b1}}) begin
         cnt_q <= cnt_q + {{(WIDTH-1){1'b0}}, 1'b1};
      end
   end

   assign count = cnt_q;
endmodule // sat_counter

// ===== core/sync_2ff.v
`timescale 1ns/10ps
// ----------------------------------------
// two-stage level synchroniser
// ----------------------------------------
module sync_2ff #(
   parameter RESET_VAL = 1'b0
) (
   input wire aclk,
   input wire aresetn,
   input wire async_in,
   output wire sync_out
);
   reg meta_q;
   reg sync_q;

   // first stage feeds only the second
   always @(posedge aclk) begin
      if (!aresetn) begin
         meta_q <= RESET_VAL;
         sync_q <= RESET_VAL;
      end else begin
         meta_q <= async_in;
         sync_q <= meta_q;
      end
   end

   assign sync_out = sync_q;
endmodule // sync_2ff

// ===== tb/analog_front_model.sv
`timescale 1ns/10ps
// ----
// integrator and comparator stand-in
// ----
module analog_front_model (
   input wire aclk,
   input wire input_connect_switch,
   input wire ref_positive_switch,
   input wire ref_negative_switch,
   input wire autozero_loop_switch,
   input wire integrator_clear_switch,
   input int vin,
   output logic comparator_high
);
   int acc_q = 0;
   // input adds vin per clock, reference removes one unit per clock
   always @(posedge aclk) begin
      if (autozero_loop_switch || integrator_clear_switch) begin
         acc_q <= 0;
      end else if (input_connect_switch) begin
         acc_q <= acc_q + vin;
      end else if (ref_positive_switch) begin
         acc_q <= acc_q - 1;
      end else if (ref_negative_switch) begin
         acc_q <= acc_q + 1;
      end
   end
   // zero reads high so both ramp directions see a crossing
   assign comparator_high = (acc_q >= 0);
endmodule // analog_front_model

// ===== tb/dss_seq_asserts.sv
`timescale 1ns/10ps
// ----
// sequencer port checks
// ----
module dss_seq_asserts #(
   parameter INT_LEN = 10000,
   parameter REF_LIMIT = 20000,
   parameter IZ_OVR_LEN = 6200
) (
   input wire aclk,
   input wire aresetn,
   input wire input_connect_switch,
   input wire ref_positive_switch,
   input wire ref_negative_switch,
   input wire autozero_loop_switch,
   input wire ref_charge_switch,
   input wire integrator_common_switch,
   input wire integrator_clear_switch,
   input wire busy,
   input wire polarity,
   input wire overrange
);
   int ic_q = 0;
   int iz_q = 0;
   int rf_q = 0;
   logic iz_ovr_q = 1'b0;
   wire ref_on = ref_positive_switch || ref_negative_switch;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // run lengths per switch; busy still high entering zero phase marks overrange
   always @(posedge aclk) begin
      ic_q <= (aresetn && input_connect_switch) ? ic_q + 1 : 0;
      iz_q <= (aresetn && integrator_clear_switch) ? iz_q + 1 : 0;
      rf_q <= (aresetn && ref_on) ? rf_q + 1 : 0;
      if (!aresetn) iz_ovr_q <= 1'b0;
      else if (integrator_clear_switch && iz_q == 0) iz_ovr_q <= busy;
   end
   input_sw_a: assert property (input_connect_switch |-> !(ref_on || autozero_loop_switch ||
      ref_charge_switch || integrator_common_switch || integrator_clear_switch)) else $error("switch beside input");
   zero_sw_a: assert property (autozero_loop_switch |-> ref_charge_switch
      && integrator_common_switch && !ref_on && !integrator_clear_switch) else $error("zero switches");
   ref_sw_a: assert property (ref_on |-> ref_positive_switch == polarity
      && !(ref_positive_switch && ref_negative_switch) && integrator_common_switch) else $error("ref switch");
   clear_sw_a: assert property (integrator_clear_switch |-> integrator_common_switch
      && !autozero_loop_switch && !ref_on) else $error("clear switches");
   int_len_a: assert property ($fell(input_connect_switch) |-> ic_q == INT_LEN)
      else $error("input span");
   iz_len_a: assert property ($fell(integrator_clear_switch) |->
      (iz_ovr_q ? iz_q == IZ_OVR_LEN : iz_q >= 100 && iz_q <= 200)) else $error("zero span");
   ref_lim_a: assert property (ref_on |-> rf_q <= REF_LIMIT) else $error("ref too long");
   busy_rise_a: assert property ($rose(busy) |-> $rose(input_connect_switch))
      else $error("busy rise");
   busy_fall_a: assert property ($fell(busy) |-> $rose(integrator_clear_switch) ||
      $fell(integrator_clear_switch)) else $error("busy fall");
   pol_latch_a: assert property ($changed(polarity) |-> $fell(input_connect_switch))
      else $error("polarity moved");
   ovr_set_a: assert property ($rose(overrange) |-> $fell(busy)) else $error("ovr set");
   ovr_clr_a: assert property ($fell(overrange) |-> ref_on) else $error("ovr clear");
   phase_ord_a: assert property ($fell(input_connect_switch) |-> ref_on ##0
      !$past(integrator_clear_switch)) else $error("phase order");
   back_sz_a: assert property ($fell(integrator_clear_switch) |-> autozero_loop_switch)
      else $error("no system zero");
   busy_c: cover property ($rose(busy));
   ovr_c: cover property ($rose(overrange));
   neg_c: cover property ($rose(ref_negative_switch));
endmodule // dss_seq_asserts

// ===== tb/dual_slope_conversion_sequencer_tb.sv
`timescale 1ns/10ps
`include "dss_map.vh"
module dual_slope_conversion_sequencer_tb;
   localparam int AZ_LEN = 20;
   localparam int INT_LEN = 20;
   localparam int REF_LIMIT = 40;
   localparam int CYCLE_LEN = 400;
   localparam int IZ_OVR_LEN = 250;
   logic aclk = 0;
   logic aresetn = 0;
   logic run_hold = 1;
   wire comparator_high, input_connect_switch, ref_positive_switch, ref_negative_switch;
   wire autozero_loop_switch, ref_charge_switch, integrator_common_switch;
   wire integrator_clear_switch, busy, polarity, overrange;
   logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [31:0] s_axi_wdata = 0;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
   logic s_axi_rready = 0;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   int vin = 1;
   int n_errors = 0, n_compared = 0, cyc = 0, rel = 0, t_rise = -1;
   logic [31:0] d;
   logic [1:0] r;
   dual_slope_conversion_sequencer #(.AZ_LEN(AZ_LEN), .INT_LEN(INT_LEN), .REF_LIMIT(REF_LIMIT),
      .CYCLE_LEN(CYCLE_LEN), .IZ_OVR_LEN(IZ_OVR_LEN)) u_dut (.aclk, .aresetn, .run_hold,
      .comparator_high, .input_connect_switch, .ref_positive_switch, .ref_negative_switch,
      .autozero_loop_switch, .ref_charge_switch, .integrator_common_switch,
      .integrator_clear_switch, .busy, .polarity, .overrange, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
   analog_front_model u_afe (.aclk, .input_connect_switch, .ref_positive_switch,
      .ref_negative_switch, .autozero_loop_switch, .integrator_clear_switch, .vin,
      .comparator_high);
   // ----
   // clock and helpers
   // ----
   initial forever #25 aclk = ~aclk;
   always @(posedge aclk) cyc <= cyc + 1;
   task automatic check(input string nm, input logic [31:0] seen, exp);
      n_compared++;
      if (seen !== exp) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // leading edge keeps back-to-back calls from double assigning
   task automatic axi_read(input logic [7:0] a);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   task automatic axi_write(input logic [7:0] a, input logic [31:0] v);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic wait_b(input logic lvl);
      int n;
      n = 0;
      while (busy !== lvl && n < 2000) begin
         @(posedge aclk);
         n++;
      end
      check("busy wait", n < 2000, 1);
   endtask
   task automatic quiet(input int c);
      int k;
      k = 0;
      repeat (c) begin
         @(posedge aclk);
         if (busy !== 1'b0) k++;
      end
      check("busy quiet", k, 0);
   endtask
   // ----
   // scenarios
   // ----
   task automatic t_regs();
      check("zero sw", {autozero_loop_switch, ref_charge_switch, integrator_common_switch,
         input_connect_switch}, 4'he);
      axi_read(8'h0c);
      check("unmapped resp", r, `DSS_RESP_SLVERR);
      check("unmapped data", d, 32'h0);
      axi_write(`DSS_STATUS_OFS, 32'hffffffff);
      check("status write", r, `DSS_RESP_OKAY);
      axi_read(`DSS_STATUS_OFS);
      check("status zero", d, 32'h8);
   endtask
   task automatic conv(input int v, input logic pol, ovr);
      vin <= v;
      wait_b(1'b1);
      if (t_rise < 0) check("az span", cyc - rel >= AZ_LEN && cyc - rel <= AZ_LEN + 6, 1);
      else check("period", cyc - t_rise, CYCLE_LEN);
      t_rise = cyc;
      repeat (2) @(posedge aclk);
      check("input sw", {input_connect_switch, integrator_common_switch}, 2'b10);
      repeat (INT_LEN + 3) @(posedge aclk);
      check("ref sw", {ref_positive_switch, ref_negative_switch, integrator_common_switch},
         {pol, !pol, 1'b1});
      wait_b(1'b0);
      repeat (3) @(posedge aclk);
      check("polarity", polarity, pol);
      check("overrange", overrange, ovr);
      axi_read(`DSS_RESULT_OFS);
      if (!ovr) check("result", d >= INT_LEN - 2 && d <= INT_LEN + 6, 1);
   endtask
   task automatic t_hold();
      logic [31:0] res;
      int k;
      wait_b(1'b1);
      run_hold <= 1'b0;
      repeat (5) @(posedge aclk);
      run_hold <= 1'b1; // pulse inside the running cycle
      repeat (10) @(posedge aclk);
      run_hold <= 1'b0;
      wait_b(1'b0);
      axi_read(`DSS_RESULT_OFS);
      res = d;
      quiet(2 * CYCLE_LEN);
      axi_read(`DSS_RESULT_OFS);
      check("held result", d, res);
      axi_read(`DSS_STATUS_OFS);
      check("hold status", d, 32'h82);
      run_hold <= 1'b1; // 400 ns high, a single shot
      repeat (8) @(posedge aclk);
      run_hold <= 1'b0;
      k = cyc;
      wait_b(1'b1);
      check("shot start", cyc - k >= AZ_LEN && cyc - k <= AZ_LEN + 12, 1);
      wait_b(1'b0);
      quiet(2 * CYCLE_LEN);
   endtask
   // soft hold must beat a running pin; the trigger bit starts exactly one cycle
   task automatic t_ctrl();
      axi_write(`DSS_CTRL_OFS, 32'h1);
      check("ctrl write", r, `DSS_RESP_OKAY);
      run_hold <= 1'b1;
      quiet(CYCLE_LEN);
      axi_write(`DSS_CTRL_OFS, 32'h3);
      axi_read(`DSS_CTRL_OFS);
      check("ctrl read", d, 32'h1);
      wait_b(1'b1);
      wait_b(1'b0);
      quiet(2 * CYCLE_LEN);
      axi_write(`DSS_CTRL_OFS, 32'h0);
      wait_b(1'b1);
   endtask
   task automatic summarize();
      $display("compared %0d errors %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // main sequence, then a watchdog sized well past the expected run
   initial begin
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      rel = cyc;
      t_regs();
      conv(1, 1'b1, 1'b0);
      conv(-1, 1'b0, 1'b0);
      conv(3, 1'b1, 1'b1);
      conv(1, 1'b1, 1'b0);
      t_hold();
      t_ctrl();
      summarize();
   end
   initial begin
      repeat (20000) @(posedge aclk);
      n_errors++;
      $display("mismatch watchdog expected finish seen timeout");
      summarize();
   end
endmodule // dual_slope_conversion_sequencer_tb
bind dual_slope_conversion_sequencer dss_seq_asserts #(.INT_LEN(INT_LEN),
   .REF_LIMIT(REF_LIMIT), .IZ_OVR_LEN(IZ_OVR_LEN)) u_chk (.aclk, .aresetn,
   .input_connect_switch, .ref_positive_switch, .ref_negative_switch, .autozero_loop_switch,
   .ref_charge_switch, .integrator_common_switch, .integrator_clear_switch, .busy,
   .polarity, .overrange);
